// ---- rtl/chb_pkg.sv ----
/*
  Shared constants and types of the charger host port and cell balance block.
  Assumes a 40 MHz core clock; all counts derive from it.
*/
package chb_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned CLK_MHZ         = CLK_HZ / 1_000_000;
  // Timing, in printed units
  localparam int unsigned BAL_PERIOD_US   = 250_000;
  localparam int unsigned BAL_MEAS_US     = 200;
  localparam int unsigned WD_UNIT_S       = 40;
  localparam int unsigned BAL_PERIOD_CYC  = BAL_PERIOD_US * CLK_MHZ;
  localparam int unsigned BAL_MEAS_CYC    = BAL_MEAS_US * CLK_MHZ;
  localparam int unsigned WD_UNIT_CYC     = 32'(WD_UNIT_S) * 32'(CLK_HZ);
  // Serial slave
  localparam logic [6:0]  SLAVE_ADDR      = 7'h4B;
  // Register offsets
  localparam logic [7:0]  OFS_CHG_VOLT    = 8'h00;
  localparam logic [7:0]  OFS_BAL_CUR     = 8'h01;
  localparam logic [7:0]  OFS_TIMER       = 8'h02;
  localparam logic [7:0]  OFS_STATUS      = 8'h03;
  localparam logic [7:0]  OFS_FAULT       = 8'h04;
  // Reset values, the fields that watchdog expiry restores and the self-clearing timer bits
  localparam logic [7:0]  RST_CHG_VOLT    = 8'h38;
  localparam logic [7:0]  RST_BAL_CUR     = 8'h8F;
  localparam logic [7:0]  RST_TIMER       = 8'h95;
  localparam logic [7:0]  WDM_CHG_VOLT    = 8'hF0;
  localparam logic [7:0]  WDM_BAL_CUR     = 8'hFF;
  localparam logic [7:0]  WDM_TIMER       = 8'h87;
  localparam logic [7:0]  TIMER_SELFCLR   = 8'h48;
  // Field positions
  localparam int unsigned F_CHG_EN        = 4;
  localparam int unsigned F_OVP_HYS       = 0;
  localparam int unsigned F_VCELL_BAL     = 6;
  localparam int unsigned F_THR_LO_HIGH   = 5;
  localparam int unsigned F_THR_HI_HIGH   = 4;
  localparam int unsigned F_WD_KICK       = 6;
  localparam int unsigned F_REG_RST       = 3;
  localparam int unsigned F_SUSP_N        = 0;
  localparam int unsigned F_WD_FAULT      = 7;
  // Cell levels in mV
  localparam logic [12:0] VBAL_START_LO   = 13'd3500;
  localparam logic [12:0] VBAL_START_HI   = 13'd3700;
  localparam logic [12:0] VDIFF_ON_LO     = 13'd50;
  localparam logic [12:0] VDIFF_ON_HI     = 13'd70;
  localparam logic [12:0] VDIFF_OFF       = 13'd30;
  localparam logic [12:0] VCELL_REG_BASE  = 13'd4150;
  localparam logic [12:0] VCELL_REG_STEP  = 13'd50;
  localparam logic [12:0] VOVP_HYS        = 13'd80;

  typedef enum logic [3:0] {
    CHB_IDLE  = 4'b0000,
    CHB_ADDR  = 4'b0001,
    CHB_AACK  = 4'b0010,
    CHB_REG   = 4'b0011,
    CHB_RACK  = 4'b0100,
    CHB_WDAT  = 4'b0101,
    CHB_WACK  = 4'b0110,
    CHB_RDAT  = 4'b0111,
    CHB_MACK  = 4'b1000
  } chb_state_t;

  typedef struct packed {
    logic [12:0] upper_mv;
    logic [12:0] lower_mv;
  } chb_cells_t;

  typedef struct packed {
    logic [5:0] status;
    logic [6:0] faults;
  } chb_core_t;
endpackage

// ---- rtl/chb_top.sv ----
/*
  Charger host port: serial register slave, watchdog, cell balance scheduler,
  cell over-voltage suspension and suspend control.
  Assumes cell voltages and core status come from logic on clk; scl and sda_i
  come from pins and are synchronised here.
  Balance switch, battery switch and boost outputs go to drivers outside this block.
*/
`timescale 1ns/1ps
module chb_top
  import chb_pkg::*;
#(
  parameter int unsigned BAL_PERIOD = BAL_PERIOD_CYC,
  parameter int unsigned BAL_MEAS   = BAL_MEAS_CYC,
  parameter int unsigned WD_UNIT    = WD_UNIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire chb_cells_t cells,
  input  wire chb_core_t  core,
  input  wire logic       charging,
  input  wire logic       term_block_opt,
  output logic            bal_upper_on,
  output logic            bal_lower_on,
  output logic            meas_slot,
  output logic            charge_run,
  output logic            batt_switch_open,
  output logic            boost_enable,
  output logic            term_inhibit,
  output logic [2:0]      vbatt_reg_code,
  output logic [2:0]      sysmin_code,
  output logic [7:0]      bal_cur_cfg
);
  // Both pins pass through matched two-stage synchronisers, so start and stop are never seen out of order
  // Pin synchronisers: stage 1 feeds stage 2 only
  logic [1:0] scl_sync_reg, sda_sync_reg;
  logic       scl_d_reg, sda_d_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end
  wire scl_s   = scl_sync_reg[1];
  wire sda_s   = sda_sync_reg[1];
  wire scl_r   = scl_s & ~scl_d_reg;
  wire scl_f   = ~scl_s & scl_d_reg;
  wire start_c = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_c  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  chb_state_t st_reg, st_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next;
  logic       rw_reg, rw_next, oe_reg, oe_next;
  logic       wr_pulse, rd_pulse, hit;
  logic [7:0] rdata;

  logic [7:0] r00_reg, r01_reg, r02_reg;
  logic       wd_fault_reg;

  wire addr_ok = (sh_reg[7:1] == SLAVE_ADDR);
  wire reg_ok  = (sh_reg <= OFS_FAULT);
  wire bit8    = (bit_reg == 4'h8);

  // Read multiplexer; reserved status bits read zero
  assign rdata = (ptr_reg == OFS_CHG_VOLT) ? r00_reg :
                 (ptr_reg == OFS_BAL_CUR)  ? r01_reg :
                 (ptr_reg == OFS_TIMER)    ? r02_reg :
                 (ptr_reg == OFS_STATUS)   ? {2'h0, core.status} :
                                             {wd_fault_reg, core.faults};

  always_comb begin
    st_next  = st_reg;
    bit_next = bit_reg;
    sh_next  = sh_reg;
    ptr_next = ptr_reg;
    rw_next  = rw_reg;
    oe_next  = oe_reg;
    wr_pulse = 1'b0;
    rd_pulse = 1'b0;
    hit      = 1'b0;
    if (start_c) begin
      st_next  = CHB_ADDR;
      bit_next = 4'h0;
      oe_next  = 1'b0;
    end else if (stop_c) begin
      st_next = CHB_IDLE;
      oe_next = 1'b0;
    end else if (scl_r && st_reg != CHB_IDLE) begin
      sh_next  = {sh_reg[6:0], sda_s};
      bit_next = bit_reg + 4'h1;
    end else if (scl_f) begin
      unique case (st_reg)
        CHB_IDLE: ;
        CHB_ADDR: if (bit8) begin
          st_next = addr_ok ? CHB_AACK : CHB_IDLE;
          oe_next = addr_ok;
          rw_next = sh_reg[0];
          hit     = addr_ok;
        end
        CHB_AACK: begin
          bit_next = 4'h0;
          st_next  = rw_reg ? CHB_RDAT : CHB_REG;
          sh_next  = rdata;
          oe_next  = rw_reg & ~rdata[7];
          rd_pulse = rw_reg;
        end
        CHB_REG: if (bit8) begin
          st_next  = reg_ok ? CHB_RACK : CHB_IDLE;
          oe_next  = reg_ok;
          ptr_next = sh_reg;
        end
        CHB_RACK: begin
          bit_next = 4'h0;
          st_next  = CHB_WDAT;
          oe_next  = 1'b0;
        end
        CHB_WDAT: if (bit8) begin
          st_next  = CHB_WACK;
          oe_next  = 1'b1;
          wr_pulse = 1'b1;
        end
        CHB_WACK: begin
          st_next = CHB_IDLE;
          oe_next = 1'b0;
        end
        CHB_RDAT: begin
          oe_next = bit8 ? 1'b0 : ~sh_reg[3'(4'h7 - bit_reg)];
          st_next = bit8 ? CHB_MACK : CHB_RDAT;
        end
        CHB_MACK: begin
          st_next = CHB_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  // The shift register doubles as the read holding byte; the rise shift is
  // skipped while transmitting so the byte stays put.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg  <= CHB_IDLE;
      bit_reg <= 4'h0;
      sh_reg  <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg  <= 1'b0;
      oe_reg  <= 1'b0;
    end else begin
      st_reg  <= st_next;
      bit_reg <= bit_next;
      sh_reg  <= (st_reg == CHB_RDAT && !start_c) ? sh_reg : sh_next;
      ptr_reg <= ptr_next;
      rw_reg  <= rw_next;
      oe_reg  <= oe_next;
    end
  end
  assign sda_o  = 1'b0;
  assign sda_oe = oe_reg;

  // Watchdog: any access to this slave restarts it
  // Expiry restores register fields only; a transfer in flight carries on
  logic [31:0] wd_pre_reg;
  logic [2:0]  wd_units_reg;
  wire  [2:0]  wd_limit = (r02_reg[5:4] == 2'h1) ? 3'h1 :
                          (r02_reg[5:4] == 2'h2) ? 3'h2 : 3'h4;
  wire         wd_on    = (r02_reg[5:4] != 2'h0);
  wire         wd_kick  = hit | (wr_pulse && ptr_reg == OFS_TIMER && sh_reg[F_WD_KICK]);
  wire         wd_tick  = (wd_pre_reg == WD_UNIT - 1);
  wire         wd_exp   = wd_on & wd_tick & (wd_units_reg + 3'd1 == wd_limit);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_pre_reg   <= 32'h0;
      wd_units_reg <= 3'h0;
    end else if (wd_kick || !wd_on || wd_exp) begin
      wd_pre_reg   <= 32'h0;
      wd_units_reg <= 3'h0;
    end else begin
      wd_pre_reg   <= wd_tick ? 32'h0 : wd_pre_reg + 32'h1;
      wd_units_reg <= wd_units_reg + {2'h0, wd_tick};
    end
  end

  // Register file; self-clearing command bits never store
  // A register reset wins over expiry and over the write that carries it
  wire soft_rst = wr_pulse && ptr_reg == OFS_TIMER && sh_reg[F_REG_RST];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r00_reg      <= RST_CHG_VOLT;
      r01_reg      <= RST_BAL_CUR;
      r02_reg      <= RST_TIMER;
      wd_fault_reg <= 1'b0;
    end else begin
      if (soft_rst) begin
        r00_reg <= RST_CHG_VOLT;
        r01_reg <= RST_BAL_CUR;
        r02_reg <= RST_TIMER;
      end else if (wd_exp) begin
        r00_reg <= (r00_reg & ~WDM_CHG_VOLT) | (RST_CHG_VOLT & WDM_CHG_VOLT);
        r01_reg <= (r01_reg & ~WDM_BAL_CUR) | (RST_BAL_CUR & WDM_BAL_CUR);
        r02_reg <= (r02_reg & ~WDM_TIMER) | (RST_TIMER & WDM_TIMER);
      end else if (wr_pulse) begin
        if (ptr_reg == OFS_CHG_VOLT) r00_reg <= sh_reg;
        if (ptr_reg == OFS_BAL_CUR) r01_reg <= sh_reg;
        if (ptr_reg == OFS_TIMER) r02_reg <= sh_reg & ~TIMER_SELFCLR;
      end
      // Expiry cause is sticky until read; a new expiry wins over the clear
      if (wd_exp)
        wd_fault_reg <= 1'b1;
      else if (rd_pulse && ptr_reg == OFS_FAULT)
        wd_fault_reg <= 1'b0;
    end
  end
  assign vbatt_reg_code = r00_reg[7:5];
  assign sysmin_code    = r00_reg[3:1];
  assign bal_cur_cfg    = r01_reg;
  assign boost_enable   = r02_reg[F_SUSP_N];

  // Balance slot timer runs from clk only
  // It ignores charging on purpose: the slot grid stays fixed, the switches are gated
  logic [31:0] slot_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      slot_reg <= 32'h0;
    else
      slot_reg <= (slot_reg == BAL_PERIOD - 1) ? 32'h0 : slot_reg + 32'h1;
  end
  wire meas     = (slot_reg < BAL_MEAS);
  wire meas_end = (slot_reg == BAL_MEAS - 1);

  chb_cells_t  cel_reg;
  logic        up_sel_reg, lo_sel_reg, ovp_reg;
  wire  [12:0] c_up     = cel_reg.upper_mv;
  wire  [12:0] c_lo     = cel_reg.lower_mv;
  wire  [12:0] diff     = (c_up > c_lo) ? c_up - c_lo : c_lo - c_up;
  wire  [12:0] v_start  = r01_reg[F_VCELL_BAL] ? VBAL_START_HI : VBAL_START_LO;
  wire  [12:0] thr_up   = r01_reg[F_THR_HI_HIGH] ? VDIFF_ON_HI : VDIFF_ON_LO;
  wire  [12:0] thr_lo   = r01_reg[F_THR_LO_HIGH] ? VDIFF_ON_HI : VDIFF_ON_LO;
  wire         can_bal  = charging & ((c_up > v_start) | (c_lo > v_start));
  wire  [12:0] vcell    = VCELL_REG_BASE + 13'(VCELL_REG_STEP * r00_reg[7:5]);
  wire  [12:0] v_ovp    = vcell + vcell / 13'h19;
  wire  [12:0] v_rec    = r00_reg[F_OVP_HYS] ? v_ovp : v_ovp - VOVP_HYS;
  wire  [12:0] n_up     = cells.upper_mv;
  wire  [12:0] n_lo     = cells.lower_mv;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cel_reg    <= '0;
      up_sel_reg <= 1'b0;
      lo_sel_reg <= 1'b0;
      ovp_reg    <= 1'b0;
    end else if (meas_end) begin
      cel_reg <= cells;
      if (n_up > v_ovp || n_lo > v_ovp)
        ovp_reg <= 1'b1;
      else if (n_up < v_rec && n_lo < v_rec)
        ovp_reg <= 1'b0;
    end else if (!can_bal) begin
      up_sel_reg <= 1'b0;
      lo_sel_reg <= 1'b0;
    end else if (slot_reg == BAL_MEAS) begin
      up_sel_reg <= (c_up > c_lo) & (up_sel_reg ? diff >= VDIFF_OFF : diff > thr_up);
      lo_sel_reg <= (c_lo > c_up) & (lo_sel_reg ? diff >= VDIFF_OFF : diff > thr_lo);
    end
  end
  // Gated combinationally so the slot forces the switches off in its first cycle
  assign meas_slot        = meas;
  assign bal_upper_on     = up_sel_reg & ~meas;
  assign bal_lower_on     = lo_sel_reg & ~meas;
  assign charge_run       = r00_reg[F_CHG_EN] & ~ovp_reg & ~|core.faults;
  assign batt_switch_open = ovp_reg;
  assign term_inhibit     = term_block_opt & (up_sel_reg | lo_sel_reg);
endmodule // chb_top

// ---- verif/chb_properties.sv ----
/* Concurrent checks on the chb_top ports: balance slot timing, switch
   gating, termination block, cell over-voltage and serial pin behaviour.
   Assumes the balance phase counter restarts at zero on reset release. */
`timescale 1ns/1ps
module chb_properties
  import chb_pkg::*;
#(
  parameter int unsigned BAL_PERIOD = BAL_PERIOD_CYC,
  parameter int unsigned BAL_MEAS   = BAL_MEAS_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic term_block_opt,
  input wire logic bal_upper_on,
  input wire logic bal_lower_on,
  input wire logic meas_slot,
  input wire logic charge_run,
  input wire logic batt_switch_open,
  input wire logic term_inhibit
);
  logic [31:0] phase_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      phase_reg <= '0;
    else
      phase_reg <= (phase_reg == BAL_PERIOD - 1) ? '0 : phase_reg + 32'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  slot_time_a: assert property (meas_slot == (phase_reg < BAL_MEAS))
    else $error("measurement slot out of step with period");
  meas_off_a: assert property (meas_slot |-> !bal_upper_on && !bal_lower_on)
    else $error("balance switch on during measurement");
  one_cell_a: assert property (!(bal_upper_on && bal_lower_on))
    else $error("both balance switches on");
  // A switch may only come on right after a fresh measurement
  bal_start_a: assert property ($rose(bal_upper_on) || $rose(bal_lower_on)
    |-> phase_reg <= BAL_MEAS + 1) else $error("balance started mid period");
  drain_only_a: assert property (sda_oe |-> !sda_o)
    else $error("data pin driven high");
  oe_scl_a: assert property ($changed(sda_oe) |-> !scl)
    else $error("data pin changed while clock high");
  term_off_a: assert property (!term_block_opt |-> !term_inhibit)
    else $error("termination blocked without option");
  term_on_a: assert property (term_block_opt && (bal_upper_on || bal_lower_on)
    |-> term_inhibit) else $error("termination not blocked while balancing");
  ovp_stop_a: assert property (batt_switch_open |-> !charge_run)
    else $error("charging during cell over-voltage");
  ovp_gate_a: assert property ($changed(batt_switch_open)
    |-> phase_reg == BAL_MEAS || phase_reg == BAL_MEAS + 1)
    else $error("over-voltage state changed outside measurement");
endmodule // chb_properties
bind chb_top chb_properties #(.BAL_PERIOD(BAL_PERIOD), .BAL_MEAS(BAL_MEAS)) u_chb_properties (
  .clk(clk), .rst(rst), .scl(scl), .sda_o(sda_o), .sda_oe(sda_oe),
  .term_block_opt(term_block_opt), .bal_upper_on(bal_upper_on),
  .bal_lower_on(bal_lower_on), .meas_slot(meas_slot), .charge_run(charge_run),
  .batt_switch_open(batt_switch_open), .term_inhibit(term_inhibit));

// ---- verif/chb_i2c_master.sv ----
/* Serial bus master model: single register writes and reads.
   Assumes an open-drain data wire with pull-up resolved by the bench. */
`timescale 1ns/1ps
module chb_i2c_master
  import chb_pkg::*;
(
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  logic r;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // 200 ns bit; callers start just after a core clock edge and every step is
  // whole clock periods, so both pins always move off the sampling edge
  task automatic bit_io(input logic b, output logic s);
    scl = 1'b0;
    #25 sda_low = ~b;
    #100 scl = 1'b1;
    #75 s = sda;
  endtask
  task automatic start();
    bit_io(1'b1, r);
    sda_low = 1'b1;
    #75;
  endtask
  task automatic stop();
    bit_io(1'b0, r);
    sda_low = 1'b0;
    #100;
  endtask
  task automatic put(input logic [7:0] d, output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, nak);
  endtask
  task automatic get(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
  endtask
  task automatic write_reg(input logic [6:0] sa, input logic [7:0] a, d, output logic nak);
    logic [2:0] n;
    start();
    put({sa, 1'b0}, n[0]);
    put(a, n[1]);
    put(d, n[2]);
    stop();
    nak = |n;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic nak);
    logic [2:0] n;
    start();
    put({SLAVE_ADDR, 1'b0}, n[0]);
    put(a, n[1]);
    start();
    put({SLAVE_ADDR, 1'b1}, n[2]);
    get(d);
    stop();
    nak = |n;
  endtask
endmodule // chb_i2c_master

// ---- verif/chb_top_test.sv ----
/* Self-checking bench for chb_top: registers over the serial port, watchdog,
   balance scheduling and cell over-voltage. Assumes master model and checker. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module chb_top_test;
  import chb_pkg::*;
  logic       clk, rst, scl, sda_low, sda_o, sda_oe, charging, term_block_opt;
  logic       bal_upper_on, bal_lower_on, meas_slot, charge_run, batt_switch_open;
  logic       boost_enable, term_inhibit, nak;
  logic [2:0] vbatt_reg_code, sysmin_code;
  logic [7:0] bal_cur_cfg;
  chb_cells_t cells;
  chb_core_t  core;
  int         n_mismatch = 0, n_tests = 0, cyc = 0;
  wire        sda = ~(sda_low | sda_oe);
  chb_top #(.BAL_PERIOD(200), .BAL_MEAS(20), .WD_UNIT(2000)) u_chb_top (
    .clk(clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .cells(cells), .core(core), .charging(charging), .term_block_opt(term_block_opt),
    .bal_upper_on(bal_upper_on), .bal_lower_on(bal_lower_on), .meas_slot(meas_slot),
    .charge_run(charge_run), .batt_switch_open(batt_switch_open),
    .boost_enable(boost_enable), .term_inhibit(term_inhibit),
    .vbatt_reg_code(vbatt_reg_code), .sysmin_code(sysmin_code), .bal_cur_cfg(bal_cur_cfg));
  chb_i2c_master u_chb_i2c_master (.scl(scl), .sda_low(sda_low), .sda(sda));
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic wr(input logic [6:0] sa, input logic [7:0] a, d, input logic e);
    u_chb_i2c_master.write_reg(sa, a, d, nak);
    @(posedge clk);
    #2 `CHK(nak, e)
  endtask
  task automatic rd(input logic [7:0] a, e);
    logic [7:0] d;
    u_chb_i2c_master.read_reg(a, d, nak);
    @(posedge clk);
    #2 `CHK({nak, d}, {1'b0, e})
  endtask
  // Two slot ends make sure a full measurement saw the new cells
  task automatic step(input logic [12:0] u, l);
    @(posedge clk);
    #2 cells = {u, l};
    repeat (2) @(negedge meas_slot);
    repeat (5) @(posedge clk);
    #2;
  endtask
  task automatic sw(input logic eu, el);
    `CHK({bal_upper_on, bal_lower_on, term_inhibit, charge_run},
      {eu, el, term_block_opt & (eu | el), 1'b1})
  endtask
  initial begin
    rst = 1'b1;
    charging = 1'b0;
    term_block_opt = 1'b0;
    cells = '0;
    core = {6'h2A, 7'h15};
    repeat (6) @(posedge clk);
    #2 rst = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    `CHK(charge_run, 1'b0)
    rd(OFS_CHG_VOLT, RST_CHG_VOLT);
    rd(OFS_BAL_CUR, RST_BAL_CUR);
    rd(OFS_TIMER, RST_TIMER);
    rd(OFS_STATUS, 8'h2A);
    rd(OFS_FAULT, 8'h15);
    wr(SLAVE_ADDR, OFS_CHG_VOLT, 8'h5A, 1'b0);
    `CHK({vbatt_reg_code, sysmin_code}, {3'h2, 3'h5})
    wr(SLAVE_ADDR, OFS_STATUS, 8'hFF, 1'b0);
    rd(OFS_STATUS, 8'h2A);
    wr(SLAVE_ADDR, 8'h05, 8'h11, 1'b1);
    wr(7'h4C, OFS_CHG_VOLT, 8'h00, 1'b1);
    rd(OFS_CHG_VOLT, 8'h5A);
    wr(SLAVE_ADDR, OFS_TIMER, 8'h94, 1'b0);
    `CHK(boost_enable, 1'b0)
    wr(SLAVE_ADDR, OFS_TIMER, 8'h95, 1'b0);
    `CHK(boost_enable, 1'b1)
    wr(SLAVE_ADDR, OFS_BAL_CUR, 8'h70, 1'b0);
    `CHK(bal_cur_cfg, 8'h70)
    repeat (2600) @(posedge clk);
    #2;
    rd(OFS_CHG_VOLT, 8'h3A);
    rd(OFS_FAULT, 8'h95);
    rd(OFS_FAULT, 8'h15);
    `CHK(bal_cur_cfg, RST_BAL_CUR)
    core = {6'h2A, 7'h00};
    step(13'd3600, 13'd3500);
    sw(1'b0, 1'b0);
    charging = 1'b1;
    step(13'd3400, 13'd3300);
    sw(1'b0, 1'b0);
    term_block_opt = 1'b1;
    step(13'd3600, 13'd3500);
    sw(1'b1, 1'b0);
    step(13'd3600, 13'd3560);
    sw(1'b1, 1'b0);
    step(13'd3600, 13'd3575);
    sw(1'b0, 1'b0);
    step(13'd3600, 13'd3660);
    sw(1'b0, 1'b1);
    wr(SLAVE_ADDR, OFS_BAL_CUR, 8'hB0, 1'b0);
    step(13'd3600, 13'd3600);
    sw(1'b0, 1'b0);
    step(13'd3600, 13'd3660);
    sw(1'b0, 1'b0);
    step(13'd3600, 13'd3680);
    sw(1'b0, 1'b1);
    step(13'd4400, 13'd4200);
    `CHK({batt_switch_open, charge_run}, 2'b10)
    step(13'd4300, 13'd4200);
    `CHK(batt_switch_open, 1'b1)
    step(13'd4250, 13'd4200);
    `CHK(batt_switch_open, 1'b0)
    wr(SLAVE_ADDR, OFS_CHG_VOLT, 8'h39, 1'b0);
    step(13'd4400, 13'd4200);
    step(13'd4360, 13'd4200);
    `CHK(batt_switch_open, 1'b0)
    end_of_test();
  end
endmodule // chb_top_test
